// ---- bench/cki_kbd_model.sv ----
// keyboard model: parallel ascii code with a key-pressed strobe
`timescale 1ns/1ns
module cki_kbd_model (
  input wire logic clk,
  input wire logic req,
  input wire cki_pkg::cki_char_t req_code,
  output cki_pkg::cki_char_t key_data,
  output logic key_strobe,
  output logic busy
);
  logic [2:0] step;

  initial begin
    key_data = 7'h00;
    key_strobe = 1'h0;
    busy = 1'h0;
    step = 3'h0;
  end

  // code steady under a two-cycle strobe, then two idle cycles
  always @(posedge clk) begin
    if (step == 3'h0) begin
      if (req === 1'h1) begin
        key_data <= req_code;
        key_strobe <= 1'h1;
        busy <= 1'h1;
        step <= 3'h1;
      end
    end else begin
      step <= step + 3'h1;
      if (step == 3'h2) begin
        key_strobe <= 1'h0;
        // released lines show no stale code
        key_data <= ~key_data;
      end
      if (step == 3'h4) begin
        busy <= 1'h0;
        step <= 3'h0;
      end
    end
  end
endmodule : cki_kbd_model

// ---- bench/test_console_keyboard_input_fifo.sv ----
// self-checking bench for the console keyboard input fifo
`timescale 1ns/1ns
module test_console_keyboard_input_fifo;
  logic clk, nrst, kbd_lockout, lock_char_wr, console_char_read;
  logic poll_read, req, key_strobe, busy, char_valid, shift_lock;
  logic console_out_valid, lk;
  logic sel, rxd, txd, smode, blk, prdy;
  cki_pkg::cki_char_t pdat;
  int bt, txbells, b;
  logic [9:0] frame;
  cki_pkg::cki_char_t req_code, key_data, lock_char_in, char_data;
  cki_pkg::cki_char_t console_out_data, got, lock_val;
  logic [7:0] console_status;
  logic [4:0] input_buffer_count;
  int fails, compares, bells, exp_bells, i;
  integer seed;
  cki_pkg::cki_char_t q[$];
  cki_pkg::cki_char_t tbl[19] = '{7'h1b, 7'h40, 7'h41, 7'h5a, 7'h5b,
    7'h60, 7'h61, 7'h7a, 7'h7b, 7'h7f, 7'h3f, 7'h41, 7'h5a, 7'h61,
    7'h7a, 7'h40, 7'h3f, 7'h20, 7'h0d};

  cki_kbd_model kbd (.clk(clk), .req(req), .req_code(req_code),
    .key_data(key_data), .key_strobe(key_strobe), .busy(busy));

  cki_top #(.SLOW_BIT_CYCLES(20'h0_0010)) uut (.clk(clk), .nrst(nrst),
    .serial_select(sel), .key_data(key_data), .key_strobe(key_strobe),
    .kbd_lockout(kbd_lockout), .lock_char_wr(lock_char_wr),
    .lock_char_in(lock_char_in), .console_char_read(console_char_read),
    .console_status(console_status), .char_valid(char_valid),
    .char_data(char_data), .input_buffer_count(input_buffer_count),
    .shift_lock(shift_lock), .console_out_valid(console_out_valid),
    .console_out_data(console_out_data), .serial_port_rxd(rxd),
    .serial_port_txd(txd), .serial_mode(smode), .baud_locked(blk),
    .poll_ready(prdy), .poll_data(pdat), .poll_read(poll_read));

  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic stop_test();
    if (fails == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  function automatic cki_pkg::cki_char_t conv(
    input cki_pkg::cki_char_t c, input logic on);
    logic letter;
    letter = (c >= 7'h41 && c <= 7'h5a) || (c >= 7'h61 && c <= 7'h7a);
    conv = (on && letter) ? c ^ 7'h20 : c;
  endfunction : conv

  // overflow warnings seen at the console output
  always @(negedge clk) begin
    if (console_out_valid === 1'h1) begin
      bells++;
      chk(console_out_data, 8'h07);
    end
  end

  // bell frames on the serial output, sampled mid-bit
  always @(negedge clk) begin
    if (nrst === 1'h1 && txd === 1'h0) begin
      repeat (bt / 2) @(negedge clk);
      frame[0] = txd;
      for (b = 1; b < 10; b++) begin
        repeat (bt) @(negedge clk);
        frame[b] = txd;
      end
      txbells++;
      chk(frame[8:1], 8'h07);
      chk({frame[9], frame[0]}, 8'h02);
    end
  end

  // serial frame: start, 7 data lsb first, odd parity, stop
  task automatic send(input cki_pkg::cki_char_t c);
    logic [9:0] f;
    f = {1'h1, ~(^c), c, 1'h0};
    for (int k = 0; k < 10; k++) begin
      @(negedge clk);
      rxd = f[k];
      repeat (bt - 1) @(negedge clk);
    end
  endtask : send

  task automatic press(input cki_pkg::cki_char_t c);
    int n;
    @(negedge clk);
    req = 1'h1;
    req_code = c;
    @(negedge clk);
    req = 1'h0;
    n = 0;
    while (busy === 1'h1 && n < 20) begin
      @(negedge clk);
      n++;
    end
  endtask : press

  task automatic typed(input cki_pkg::cki_char_t c);
    if (c === lock_val) lk = ~lk;
    else if (q.size() < 16) q.push_back(conv(c, lk));
    else exp_bells++;
    if (sel) send(c);
    else press(c);
    chk(input_buffer_count, q.size());
    chk(shift_lock, lk);
    chk(console_status, q.size() ? 8'hff : 8'h00);
    chk(bells, exp_bells);
  endtask : typed

  task automatic pop(output cki_pkg::cki_char_t v);
    int n;
    @(negedge clk);
    console_char_read = 1'h1;
    n = 0;
    while (char_valid !== 1'h1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    v = char_data;
    console_char_read = 1'h0;
    chk(char_valid, 8'h01);
  endtask : pop

  task automatic rd();
    cki_pkg::cki_char_t e;
    e = q.pop_front();
    pop(got);
    chk(got, e);
    chk(input_buffer_count, q.size());
  endtask : rd

  task automatic set_lock(input cki_pkg::cki_char_t c);
    @(negedge clk);
    lock_char_wr = 1'h1;
    lock_char_in = c;
    @(negedge clk);
    lock_char_wr = 1'h0;
    lock_val = c;
  endtask : set_lock

  initial begin
    nrst = 1'h0;
    kbd_lockout = 1'h0;
    lock_char_wr = 1'h0;
    lock_char_in = 7'h00;
    console_char_read = 1'h0;
    poll_read = 1'h0;
    req = 1'h0;
    req_code = 7'h00;
    fails = 0;
    compares = 0;
    bells = 0;
    exp_bells = 0;
    seed = 32'h35bb_c37b;
    lk = 1'h0;
    lock_val = 7'h00;
    sel = 1'h0;
    rxd = 1'h1;
    bt = 16;
    txbells = 0;
    repeat (16) @(negedge clk);
    nrst = 1'h1;
    chk(input_buffer_count, 8'h00);
    chk(console_status, 8'h00);
    // nul acts as the lock character out of reset
    typed(7'h00);
    typed(7'h61);
    typed(7'h00);
    typed(7'h61);
    rd();
    rd();
    set_lock(7'h1b);
    // boundary codes past a full buffer, then drain
    foreach (tbl[k]) typed(tbl[k]);
    while (q.size() > 0) rd();
    // strobe lost during disk lockout
    @(negedge clk);
    kbd_lockout = 1'h1;
    press(7'h41);
    kbd_lockout = 1'h0;
    chk(input_buffer_count, 8'h00);
    chk(shift_lock, lk);
    for (i = 0; i < 60; i++) begin
      poll_read = 1'($random(seed));
      if (($random(seed) & 3) != 0 || q.size() == 0)
        typed(7'($random(seed)));
      else
        rd();
    end
    while (q.size() > 0) rd();
    if (!lk) typed(7'h1b);
    // read waits on an empty buffer until a key arrives
    fork
      pop(got);
      begin
        repeat (4) @(negedge clk);
        chk(char_valid, 8'h00);
        press(7'h3a);
      end
    join
    chk(got, 8'h3a);
    // keyboard console: serial char only held for polling
    poll_read = 1'h0;
    chk(prdy, 8'h00);
    send(7'h55);
    chk(prdy, 8'h01);
    chk(pdat, 8'h55);
    chk(input_buffer_count, 8'h00);
    poll_read = 1'h1;
    @(negedge clk);
    poll_read = 1'h0;
    chk(prdy, 8'h00);
    // second reset straps the serial console at a new bit rate
    @(negedge clk);
    nrst = 1'h0;
    sel = 1'h1;
    bt = 12;
    repeat (16) @(negedge clk);
    nrst = 1'h1;
    q.delete();
    lk = 1'h0;
    lock_val = 7'h00;
    chk(smode, 8'h01);
    chk(blk, 8'h00);
    chk(input_buffer_count, 8'h00);
    send(7'h0d);
    chk(blk, 8'h01);
    chk(input_buffer_count, 8'h00);
    press(7'h41);
    chk(input_buffer_count, 8'h00);
    typed(7'h00);
    for (i = 0; i < 17; i++) typed(7'h61 + 7'(i));
    while (q.size() > 0) rd();
    repeat (160) @(negedge clk);
    chk(txbells, 8'h01);
    stop_test();
  end

  initial begin
    #(20000 * 8);
    fails++;
    stop_test();
  end
endmodule : test_console_keyboard_input_fifo

// ---- verilog/cki_defs.svh ----
// constants for the console keyboard input fifo
// Behaviour
// - accepted characters held in a 16-entry first-in first-out buffer
// - character arriving at full buffer is dropped and bell 07 sent out
// - shift-lock character is programmable and resets to 00
// - shift-lock character is not stored; it toggles the shift-lock flag
// - while flag set, letters are stored in the opposite case
// - codes below 40 are stored unchanged regardless of the flag
// - keyboard strobes during disk lockout are lost
// - serial console characters enter the same buffer, same overflow rule
// - serial link is 7 data bits, odd parity, 1 stop bit, both ways
// - serial console: wait for carriage return and measure its bit rate
// - keyboard console: serial port runs 300 baud, polled, no buffering
// - status reads ff when at least one character is waiting
// - read returns oldest character, waiting while buffer is empty
`ifndef CKI_DEFS_SVH
`define CKI_DEFS_SVH
`define CKI_DEPTH 5'h10
`define CKI_BELL_CODE 7'h07
`define CKI_LOCK_RESET 7'h00
`define CKI_CASE_MIN 7'h40
`define CKI_UPPER_LO 7'h41
`define CKI_UPPER_HI 7'h5a
`define CKI_LOWER_LO 7'h61
`define CKI_LOWER_HI 7'h7a
`define CKI_CASE_BIT 5
`define CKI_STATUS_READY 8'hff
`define CKI_STATUS_EMPTY 8'h00
`define CKI_CLK_HZ 125000000
`define CKI_SLOW_BAUD 300
`define CKI_SLOW_BIT_CYCLES (`CKI_CLK_HZ / `CKI_SLOW_BAUD)
`define CKI_DATA_BITS 4'h7
`define CKI_FRAME_BITS 4'ha
`endif

// ---- verilog/cki_fifo_mem.sv ----
// sixteen-word character store with registered read data
`timescale 1ns/1ns
module cki_fifo_mem (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire cki_pkg::cki_char_t wr_data,
  input wire logic rd_en,
  input wire logic [3:0] rd_addr,
  output cki_pkg::cki_char_t rd_data
);
  cki_pkg::cki_char_t mem [0:15];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule : cki_fifo_mem

// ---- verilog/cki_pkg.sv ----
// types for the console keyboard input fifo
package cki_pkg;
  typedef logic [6:0] cki_char_t;
  typedef logic [19:0] cki_baud_t;
  typedef enum logic [5:0] {
    CKI_RX_IDLE = 6'b00_0001,
    CKI_RX_START = 6'b00_0010,
    CKI_RX_DATA = 6'b00_0100,
    CKI_RX_STOP = 6'b00_1000,
    CKI_RX_MEAS = 6'b01_0000,
    CKI_RX_SKIP = 6'b10_0000
  } cki_rx_state_t;
endpackage : cki_pkg

// ---- verilog/cki_serial_rx.sv ----
// serial receiver, 7 data bits odd parity, with start-bit rate measurement
`timescale 1ns/1ns
`include "cki_defs.svh"
module cki_serial_rx (
  input wire logic clk,
  input wire logic nrst,
  input wire logic rxd,
  input wire logic measure,
  input wire cki_pkg::cki_baud_t bit_cycles,
  output logic rx_valid,
  output cki_pkg::cki_char_t rx_data,
  output logic rx_parity_err,
  output logic baud_valid,
  output cki_pkg::cki_baud_t baud_cycles
);
  cki_pkg::cki_rx_state_t state;
  cki_pkg::cki_baud_t cnt;
  logic [3:0] bits;
  logic [7:0] shreg;
  logic rxd_q;
  logic bit_end;

  assign bit_end = (cnt == bit_cycles - 20'h0_0001);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rxd_q <= 1'b1;
    end else begin
      rxd_q <= rxd;
    end
  end

  // 7 data + odd parity, lsb first; carriage return start bit timed
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= cki_pkg::CKI_RX_IDLE;
      cnt <= 20'h0_0000;
      bits <= 4'h0;
      shreg <= 8'h00;
      rx_valid <= 1'b0;
      rx_data <= 7'h00;
      rx_parity_err <= 1'b0;
      baud_valid <= 1'b0;
      baud_cycles <= 20'h0_0000;
    end else begin
      rx_valid <= 1'b0;
      baud_valid <= 1'b0;
      cnt <= cnt + 20'h0_0001;
      unique case (state)
        cki_pkg::CKI_RX_IDLE: begin
          cnt <= 20'h0_0001;
          if (rxd_q && !rxd) begin
            state <= measure ? cki_pkg::CKI_RX_MEAS : cki_pkg::CKI_RX_START;
          end
        end
        cki_pkg::CKI_RX_START: begin
          if (cnt == {1'b0, bit_cycles[19:1]}) begin
            cnt <= 20'h0_0000;
            bits <= 4'h0;
            state <= rxd ? cki_pkg::CKI_RX_IDLE : cki_pkg::CKI_RX_DATA;
          end
        end
        cki_pkg::CKI_RX_DATA: begin
          if (bit_end) begin
            cnt <= 20'h0_0000;
            shreg <= {rxd, shreg[7:1]};
            bits <= bits + 4'h1;
            if (bits == `CKI_DATA_BITS) begin
              state <= cki_pkg::CKI_RX_STOP;
            end
          end
        end
        cki_pkg::CKI_RX_STOP: begin
          if (bit_end) begin
            rx_valid <= rxd;
            rx_data <= shreg[6:0];
            rx_parity_err <= ~(^shreg);
            state <= cki_pkg::CKI_RX_IDLE;
          end
        end
        cki_pkg::CKI_RX_MEAS: begin
          // low time of the carriage return start bit is one bit
          if (rxd) begin
            baud_valid <= 1'b1;
            baud_cycles <= cnt;
            cnt <= 20'h0_0001;
            bits <= 4'h0;
            state <= cki_pkg::CKI_RX_SKIP;
          end
        end
        cki_pkg::CKI_RX_SKIP: begin
          // let the rest of the carriage return go by
          if (cnt == baud_cycles) begin
            cnt <= 20'h0_0001;
            bits <= bits + 4'h1;
            if (bits == `CKI_DATA_BITS) begin
              state <= cki_pkg::CKI_RX_IDLE;
            end
          end
        end
        default: begin
          state <= cki_pkg::CKI_RX_IDLE;
        end
      endcase
    end
  end

  sequence meas_end_s;
    state == cki_pkg::CKI_RX_MEAS && rxd;
  endsequence

  baud_capture_a: assert property (
    @(posedge clk) disable iff (!nrst)
    meas_end_s |=> baud_valid && baud_cycles == $past(cnt))
    else $error("measured bit time not reported");

  parity_check_a: assert property (
    @(posedge clk) disable iff (!nrst)
    rx_valid |-> rx_parity_err == ~(^shreg))
    else $error("parity flag disagrees with received frame");
endmodule : cki_serial_rx

// ---- verilog/cki_top.sv ----
// console input: keyboard and serial capture, shift lock, 16-deep fifo
`timescale 1ns/1ns
`include "cki_defs.svh"
module cki_top #(
  parameter logic [19:0] SLOW_BIT_CYCLES = 20'(`CKI_SLOW_BIT_CYCLES)
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic serial_select,
  input wire cki_pkg::cki_char_t key_data,
  input wire logic key_strobe,
  input wire logic kbd_lockout,
  input wire logic lock_char_wr,
  input wire cki_pkg::cki_char_t lock_char_in,
  input wire logic console_char_read,
  output logic [7:0] console_status,
  output logic char_valid,
  output cki_pkg::cki_char_t char_data,
  output logic [4:0] input_buffer_count,
  output logic shift_lock,
  output logic console_out_valid,
  output cki_pkg::cki_char_t console_out_data,
  input wire logic serial_port_rxd,
  output logic serial_port_txd,
  output logic serial_mode,
  output logic baud_locked,
  output logic poll_ready,
  output cki_pkg::cki_char_t poll_data,
  input wire logic poll_read
);
  cki_pkg::cki_char_t lock_char;
  cki_pkg::cki_char_t in_char;
  cki_pkg::cki_char_t stored_char;
  cki_pkg::cki_char_t rx_data;
  cki_pkg::cki_baud_t bit_cycles;
  cki_pkg::cki_baud_t baud_cycles;
  cki_pkg::cki_baud_t tx_cnt;
  logic [3:0] wr_ptr;
  logic [3:0] rd_ptr;
  logic [3:0] tx_bits;
  logic [9:0] tx_shift;
  logic strobe_q;
  logic key_event;
  logic in_valid;
  logic is_lock;
  logic full;
  logic push;
  logic pop;
  logic overflow;
  logic rx_valid;
  logic baud_valid;
  logic tx_busy;

  function automatic cki_pkg::cki_char_t flip_case(input cki_pkg::cki_char_t c);
    logic letter;
    letter = (c >= `CKI_UPPER_LO && c <= `CKI_UPPER_HI) ||
             (c >= `CKI_LOWER_LO && c <= `CKI_LOWER_HI);
    flip_case = c;
    if (c >= `CKI_CASE_MIN && letter) begin
      flip_case[`CKI_CASE_BIT] = ~c[`CKI_CASE_BIT];
    end
  endfunction : flip_case

  cki_serial_rx u_rx (
    .clk(clk),
    .nrst(nrst),
    .rxd(serial_port_rxd),
    .measure(serial_mode && !baud_locked),
    .bit_cycles(bit_cycles),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .rx_parity_err(),
    .baud_valid(baud_valid),
    .baud_cycles(baud_cycles)
  );

  // console kind is strapped while reset is held
  always_ff @(posedge clk) begin
    if (!nrst) begin
      serial_mode <= serial_select;
    end
  end

  // keyboard console starts at the slow polled rate
  always_ff @(posedge clk) begin
    if (!nrst) begin
      bit_cycles <= SLOW_BIT_CYCLES;
      baud_locked <= 1'b0;
    end else if (baud_valid && serial_mode && !baud_locked) begin
      bit_cycles <= baud_cycles;
      baud_locked <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= key_strobe;
    end
  end

  // strobe edge lost while disk lockout is up
  assign key_event = key_strobe && !strobe_q && !kbd_lockout;

  // serial chars buffered only once the console rate is known
  always_comb begin
    if (serial_mode) begin
      in_valid = rx_valid && baud_locked;
      in_char = rx_data;
    end else begin
      in_valid = key_event;
      in_char = key_data;
    end
  end

  // keyboard console: serial data kept for polling only
  always_ff @(posedge clk) begin
    if (!nrst) begin
      poll_ready <= 1'b0;
      poll_data <= 7'h00;
    end else if (rx_valid && !serial_mode) begin
      poll_ready <= 1'b1;
      poll_data <= rx_data;
    end else if (poll_read) begin
      poll_ready <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      lock_char <= `CKI_LOCK_RESET;
    end else if (lock_char_wr) begin
      lock_char <= lock_char_in;
    end
  end

  assign is_lock = in_valid && in_char == lock_char;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      shift_lock <= 1'b0;
    end else if (is_lock) begin
      shift_lock <= ~shift_lock;
    end
  end

  // below 40 and non-letters pass unchanged
  assign stored_char = shift_lock ? flip_case(in_char) : in_char;

  assign full = input_buffer_count == `CKI_DEPTH;
  assign push = in_valid && !is_lock && !full;
  assign overflow = in_valid && !is_lock && full;
  assign pop = console_char_read && input_buffer_count != 5'h00;

  cki_fifo_mem u_mem (
    .clk(clk),
    .wr_en(push),
    .wr_addr(wr_ptr),
    .wr_data(stored_char),
    .rd_en(pop),
    .rd_addr(rd_ptr),
    .rd_data(char_data)
  );

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 4'h1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 4'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      input_buffer_count <= 5'h00;
    end else if (push && !pop) begin
      input_buffer_count <= input_buffer_count + 5'h01;
    end else if (pop && !push) begin
      input_buffer_count <= input_buffer_count - 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      char_valid <= 1'b0;
    end else begin
      char_valid <= pop;
    end
  end

  // status ff while anything waits
  assign console_status = (input_buffer_count != 5'h00) ?
                          `CKI_STATUS_READY : `CKI_STATUS_EMPTY;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      console_out_valid <= 1'b0;
      console_out_data <= 7'h00;
    end else begin
      console_out_valid <= overflow;
      console_out_data <= `CKI_BELL_CODE;
    end
  end

  // bell echoed on the serial line in serial console mode
  assign tx_busy = tx_bits != 4'h0;
  assign serial_port_txd = tx_shift[0];

  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_shift <= 10'h3ff;
      tx_bits <= 4'h0;
      tx_cnt <= 20'h0_0000;
    end else if (!tx_busy) begin
      if (overflow && serial_mode && baud_locked) begin
        tx_shift <= {1'b1, ~(^`CKI_BELL_CODE), `CKI_BELL_CODE, 1'b0};
        tx_bits <= `CKI_FRAME_BITS;
        tx_cnt <= 20'h0_0000;
      end
    end else if (tx_cnt == bit_cycles - 20'h0_0001) begin
      tx_cnt <= 20'h0_0000;
      tx_shift <= {1'b1, tx_shift[9:1]};
      tx_bits <= tx_bits - 4'h1;
    end else begin
      tx_cnt <= tx_cnt + 20'h0_0001;
    end
  end

  sequence lock_hit_s;
    in_valid && in_char == lock_char;
  endsequence

  sequence low_code_s;
    push && in_char < `CKI_CASE_MIN;
  endsequence

  lock_toggle_a: assert property (
    @(posedge clk) disable iff (!nrst)
    lock_hit_s |=> shift_lock != $past(shift_lock) &&
      input_buffer_count <= $past(input_buffer_count))
    else $error("lock character stored or flag not toggled");

  low_passthru_a: assert property (
    @(posedge clk) disable iff (!nrst)
    low_code_s |-> stored_char == in_char)
    else $error("code below 40 was altered");

  case_flip_a: assert property (
    @(posedge clk) disable iff (!nrst)
    push && shift_lock && in_char >= `CKI_UPPER_LO &&
      in_char <= `CKI_UPPER_HI |-> stored_char == (in_char | 7'h20))
    else $error("upper case letter not flipped under shift lock");

  overflow_bell_a: assert property (
    @(posedge clk) disable iff (!nrst)
    overflow |=> console_out_valid && console_out_data == 7'h07 &&
      input_buffer_count == 5'h10 - 5'($past(pop)))
    else $error("overflow did not ring the bell or changed count");

  count_track_a: assert property (
    @(posedge clk) disable iff (!nrst)
    push && !pop |=> input_buffer_count == $past(input_buffer_count) + 5'h01)
    else $error("count did not rise on write");

  count_limit_a: assert property (
    @(posedge clk) disable iff (!nrst)
    input_buffer_count <= 5'h10)
    else $error("buffer count beyond sixteen");

  status_ready_a: assert property (
    @(posedge clk) disable iff (!nrst)
    push ##1 !pop |-> console_status == 8'hff)
    else $error("status not ff with data waiting");

  read_wait_a: assert property (
    @(posedge clk) disable iff (!nrst)
    console_char_read && input_buffer_count == 5'h00 |=> !char_valid)
    else $error("read answered from an empty buffer");

  lockout_drop_a: assert property (
    @(posedge clk) disable iff (!nrst)
    !serial_mode && kbd_lockout |-> !push)
    else $error("keyboard character taken during lockout");

  lock_reset_a: assert property (
    @(posedge clk)
    !nrst |=> lock_char == 7'h00)
    else $error("lock character not cleared by reset");

  slow_rate_a: assert property (
    @(posedge clk) disable iff (!nrst)
    !serial_mode |-> bit_cycles == SLOW_BIT_CYCLES &&
      (!rx_valid || key_event || !push))
    else $error("keyboard console serial data reached the buffer");

  serial_enter_a: assert property (
    @(posedge clk) disable iff (!nrst)
    serial_mode && baud_locked && rx_valid && rx_data != lock_char &&
      !full |-> push)
    else $error("serial character not buffered");
endmodule : cki_top
